// file: rtl/mau_pkg.sv
package mau_pkg;
    // Register addresses on the special-function-register bus.
    localparam logic [7:0] ADDR_OPERAND_A_LOW = 8'ha4;
    localparam logic [7:0] ADDR_OPERAND_A_HIGH = 8'ha5;
    localparam logic [7:0] ADDR_ARITH_STATUS = 8'hcf;
    localparam logic [7:0] ADDR_ARITH_CONFIG = 8'hd7;
    localparam logic [7:0] ADDR_OPERAND_B_HIGH = 8'hf2;
    localparam logic [7:0] ADDR_OPERAND_B_LOW_START = 8'hf1;
    localparam logic [7:0] ADDR_ACCUM_BYTE0 = 8'h93;
    localparam logic [7:0] ADDR_ACCUM_BYTE1 = 8'h94;
    localparam logic [7:0] ADDR_ACCUM_BYTE2 = 8'h95;
    localparam logic [7:0] ADDR_ACCUM_BYTE3 = 8'h96;
    localparam logic [7:0] ADDR_ACCUM_TOP_BYTE = 8'h9d;
    localparam logic [7:0] ADDR_ROUNDED_HIGH = 8'hcd;
    localparam logic [7:0] ADDR_ROUNDED_LOW = 8'hce;

    // Configuration register fields.
    localparam int CFG_OPERATION_SELECT = 0;
    localparam int CFG_FRACTIONAL_SELECT = 1;
    localparam int CFG_SATURATE_ENABLE = 2;
    localparam int CFG_CLEAR_ACCUM = 3;
    localparam int CFG_SHIFT_DIRECTION = 4;
    localparam int CFG_SHIFT_GO = 5;
    localparam logic [7:0] CFG_WRITE_MASK = 8'h3f;
    localparam logic [7:0] CFG_RESET = 8'h00;

    // Status register fields.
    localparam int STA_NEGATIVE = 0;
    localparam int STA_SOFT_OVERFLOW = 1;
    localparam int STA_ZERO = 2;
    localparam int STA_HARD_OVERFLOW = 3;
    localparam logic [3:0] STA_RESET = 4'h4;

    // Datapath widths and rounding constants.
    localparam int ACC_W = 40;
    localparam logic [15:0] ROUND_HALF = 16'h8000;
    localparam logic [15:0] SAT_POSITIVE = 16'h7fff;
    localparam logic [15:0] SAT_NEGATIVE = 16'h8000;
    localparam logic [7:0] TOP_WRAP_POS = 8'h7f;
    localparam logic [7:0] TOP_WRAP_NEG = 8'h80;
    localparam logic [7:0] BYTE_RESET = 8'h00;
endpackage

// file: rtl/mau_top.sv
`timescale 1ns/1ps
`default_nettype none

module mau_top
    import mau_pkg::*;
(
    input wire logic clock_in,           // System clock, 10 MHz.
    input wire logic reset_n_in,         // Asynchronous reset, active low.
    input wire logic [7:0] sfr_addr_in,  // Register address.
    input wire logic sfr_wr_in,          // Write strobe, one cycle.
    input wire logic [7:0] sfr_wdata_in, // Write data.
    output logic [7:0] sfr_rdata_out     // Read data, one cycle after address.
);

    ////////////////////////////////////////////////////////////////////////
    // Register storage.

    logic [7:0] op_a_low_ff;
    logic [7:0] op_a_high_ff;
    logic [7:0] op_b_low_ff;
    logic [7:0] op_b_high_ff;
    logic [7:0] config_ff;
    logic [3:0] status_ff;
    logic [ACC_W-1:0] accum_ff;
    logic [15:0] rounded_ff;
    logic [7:0] rdata_ff;

    // Pipeline state.
    logic stage1_valid_ff;
    logic stage2_valid_ff;
    logic round_pending_ff;
    logic stage1_accumulate_ff;
    logic [ACC_W-1:0] product_ff;

    logic wr_a_low;
    logic wr_a_high;
    logic wr_b_low;
    logic wr_b_high;
    logic wr_config;
    logic wr_status;
    logic wr_acc0;
    logic wr_acc1;
    logic wr_acc2;
    logic wr_acc3;
    logic wr_top;

    assign wr_a_low = sfr_wr_in && (sfr_addr_in == ADDR_OPERAND_A_LOW);
    assign wr_a_high = sfr_wr_in && (sfr_addr_in == ADDR_OPERAND_A_HIGH);
    assign wr_b_low = sfr_wr_in && (sfr_addr_in == ADDR_OPERAND_B_LOW_START);
    assign wr_b_high = sfr_wr_in && (sfr_addr_in == ADDR_OPERAND_B_HIGH);
    assign wr_config = sfr_wr_in && (sfr_addr_in == ADDR_ARITH_CONFIG);
    assign wr_status = sfr_wr_in && (sfr_addr_in == ADDR_ARITH_STATUS);
    assign wr_acc0 = sfr_wr_in && (sfr_addr_in == ADDR_ACCUM_BYTE0);
    assign wr_acc1 = sfr_wr_in && (sfr_addr_in == ADDR_ACCUM_BYTE1);
    assign wr_acc2 = sfr_wr_in && (sfr_addr_in == ADDR_ACCUM_BYTE2);
    assign wr_acc3 = sfr_wr_in && (sfr_addr_in == ADDR_ACCUM_BYTE3);
    assign wr_top = sfr_wr_in && (sfr_addr_in == ADDR_ACCUM_TOP_BYTE);

    logic do_shift;
    logic do_clear;
    assign do_shift = config_ff[CFG_SHIFT_GO];
    assign do_clear = config_ff[CFG_CLEAR_ACCUM];

    ////////////////////////////////////////////////////////////////////////
    // Operand registers.

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            op_a_low_ff <= BYTE_RESET;
            op_a_high_ff <= BYTE_RESET;
            op_b_low_ff <= BYTE_RESET;
            op_b_high_ff <= BYTE_RESET;
        end else begin
            if (wr_a_low) begin
                op_a_low_ff <= sfr_wdata_in;
            end
            if (wr_a_high) begin
                op_a_high_ff <= sfr_wdata_in;
            end
            if (wr_b_low) begin
                op_b_low_ff <= sfr_wdata_in;
            end
            if (wr_b_high) begin
                op_b_high_ff <= sfr_wdata_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration register.

    // A write in the same cycle as the self-clear wins, so back-to-back
    // shift commands each produce one shift.
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            config_ff <= CFG_RESET;
        end else if (wr_config) begin
            config_ff <= sfr_wdata_in & CFG_WRITE_MASK;
        end else begin
            config_ff[CFG_SHIFT_GO] <= 1'b0;
            config_ff[CFG_CLEAR_ACCUM] <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stage one: multiply.

    logic signed [31:0] product_raw;
    logic [ACC_W-1:0] product_ext;

    assign product_raw = $signed({op_a_high_ff, op_a_low_ff}) *
                         $signed({op_b_high_ff, op_b_low_ff});

    // fractional results shift left one place
    always_comb begin
        product_ext = {{8{product_raw[31]}}, product_raw};
        if (config_ff[CFG_FRACTIONAL_SELECT]) begin
            product_ext = {product_ext[ACC_W-2:0], 1'b0};
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            stage1_valid_ff <= 1'b0;
            stage2_valid_ff <= 1'b0;
            stage1_accumulate_ff <= 1'b0;
            product_ff <= '0;
        end else begin
            // The operand B low byte lands on the same edge that starts the
            // operation, so the multiply runs one cycle later with fresh
            // operands.
            stage1_valid_ff <= wr_b_low;
            stage2_valid_ff <= stage1_valid_ff;
            if (stage1_valid_ff) begin
                product_ff <= product_ext;
                stage1_accumulate_ff <= !config_ff[CFG_OPERATION_SELECT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stage two: add, accumulator and flags.

    logic [ACC_W-1:0] acc_base;
    logic [ACC_W-1:0] sum;
    logic [ACC_W-1:0] shifted;
    logic sum_soft_ovf;
    logic sum_hard_ovf;

    // cleared accumulator feeds a same-cycle add
    assign acc_base = do_clear ? '0 : accum_ff;

    assign sum = stage1_accumulate_ff ? acc_base + product_ff : product_ff;

    assign sum_soft_ovf = !((&sum[ACC_W-1:31]) || !(|sum[ACC_W-1:31]));

    // top byte wrap in accumulate mode
    assign sum_hard_ovf = stage1_accumulate_ff &&
        (((acc_base[39:32] == TOP_WRAP_POS) && (sum[39:32] == TOP_WRAP_NEG)) ||
         ((acc_base[39:32] == TOP_WRAP_NEG) && (sum[39:32] == TOP_WRAP_POS)));

    always_comb begin
        if (config_ff[CFG_SHIFT_DIRECTION]) begin
            shifted = {accum_ff[ACC_W-1], accum_ff[ACC_W-1:1]};
        end else begin
            shifted = {accum_ff[ACC_W-2:0], 1'b0};
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            accum_ff <= '0;
        end else if (stage2_valid_ff) begin
            accum_ff <= sum;
        end else if (do_clear) begin
            accum_ff <= '0;
        end else if (do_shift) begin
            accum_ff <= shifted;
        end else begin
            if (wr_acc0) begin
                accum_ff[7:0] <= sfr_wdata_in;
            end
            if (wr_acc1) begin
                accum_ff[15:8] <= sfr_wdata_in;
            end
            if (wr_acc2) begin
                accum_ff[23:16] <= sfr_wdata_in;
            end
            if (wr_acc3) begin
                accum_ff[31:24] <= sfr_wdata_in;
            end
            if (wr_top) begin
                accum_ff[39:32] <= sfr_wdata_in;
            end
        end
    end

    // Status: hardware events win over a software write in the same cycle.
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            status_ff <= STA_RESET;
        end else if (stage2_valid_ff) begin
            status_ff[STA_ZERO] <= (sum == '0);
            status_ff[STA_NEGATIVE] <= sum[ACC_W-1];
            status_ff[STA_SOFT_OVERFLOW] <= sum_soft_ovf;
            status_ff[STA_HARD_OVERFLOW] <= sum_hard_ovf ||
                (do_clear ? 1'b0 : status_ff[STA_HARD_OVERFLOW]);
        end else if (do_clear) begin
            status_ff <= STA_RESET;
        end else if (wr_status) begin
            status_ff <= sfr_wdata_in[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stage three: rounding and saturation.

    logic round_up;
    logic [16:0] round_sum;
    logic acc_soft_ovf;
    logic [15:0] rounded_next;

    assign round_up = (accum_ff[15:0] > ROUND_HALF) ||
                      ((accum_ff[15:0] == ROUND_HALF) && accum_ff[16]);
    assign round_sum = {1'b0, accum_ff[31:16]} + {16'h0000, round_up};

    // Overflow if the value is out of 32-bit range or rounding runs a
    // positive value past the top of the 16-bit field.
    assign acc_soft_ovf =
        !((&accum_ff[ACC_W-1:31]) || !(|accum_ff[ACC_W-1:31]))
        || (!accum_ff[ACC_W-1] && round_sum[15] && !accum_ff[31]);

    always_comb begin
        rounded_next = round_sum[15:0];
        if (config_ff[CFG_SATURATE_ENABLE] && acc_soft_ovf) begin
            rounded_next = accum_ff[ACC_W-1] ? SAT_NEGATIVE : SAT_POSITIVE;
        end
    end

    // Rounding follows the add stage, a shift, a clear, or a write of byte 0.
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            round_pending_ff <= 1'b0;
        end else begin
            round_pending_ff <= stage2_valid_ff || do_shift ||
                                do_clear || wr_acc0;
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rounded_ff <= 16'h0000;
        end else if (round_pending_ff) begin
            rounded_ff <= rounded_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data.

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_ff <= BYTE_RESET;
        end else begin
            case (sfr_addr_in)
                ADDR_OPERAND_A_LOW: begin
                    rdata_ff <= op_a_low_ff;
                end
                ADDR_OPERAND_A_HIGH: begin
                    rdata_ff <= op_a_high_ff;
                end
                ADDR_OPERAND_B_LOW_START: begin
                    rdata_ff <= op_b_low_ff;
                end
                ADDR_OPERAND_B_HIGH: begin
                    rdata_ff <= op_b_high_ff;
                end
                ADDR_ARITH_CONFIG: begin
                    rdata_ff <= config_ff;
                end
                ADDR_ARITH_STATUS: begin
                    rdata_ff <= {4'h0, status_ff};
                end
                ADDR_ACCUM_BYTE0: begin
                    rdata_ff <= accum_ff[7:0];
                end
                ADDR_ACCUM_BYTE1: begin
                    rdata_ff <= accum_ff[15:8];
                end
                ADDR_ACCUM_BYTE2: begin
                    rdata_ff <= accum_ff[23:16];
                end
                ADDR_ACCUM_BYTE3: begin
                    rdata_ff <= accum_ff[31:24];
                end
                ADDR_ACCUM_TOP_BYTE: begin
                    rdata_ff <= accum_ff[39:32];
                end
                ADDR_ROUNDED_HIGH: begin
                    rdata_ff <= rounded_ff[15:8];
                end
                ADDR_ROUNDED_LOW: begin
                    rdata_ff <= rounded_ff[7:0];
                end
                default: begin
                    rdata_ff <= BYTE_RESET;
                end
            endcase
        end
    end

    assign sfr_rdata_out = rdata_ff;

endmodule // mau_top

`default_nettype wire

// file: testbench/mau_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none

module mau_cpu_model (
    input wire logic clock_in,        // System clock.
    input wire logic [7:0] rdata_in,  // Read data from the block.
    output logic [7:0] addr_out,      // Register address.
    output logic wr_out,              // Write strobe.
    output logic [7:0] wdata_out      // Write data.
);
    initial begin
        addr_out = 8'h00;
        wr_out = 1'b0;
        wdata_out = 8'h00;
    end
    ////////////////////////////////////////////////////////////
    // Callers enter one step after an edge; the strobe stays up so that
    // back-to-back writes need no gap cycle.
    task automatic put_reg(input logic [7:0] a, input logic [7:0] d);
        addr_out = a;
        wdata_out = d;
        wr_out = 1'b1;
        @(posedge clock_in);
        #1;
    endtask
    // Idle data toggles so that a stale byte is never mistaken for a write.
    task automatic get_reg(input logic [7:0] a, output logic [7:0] d);
        wr_out = 1'b0;
        wdata_out = ~wdata_out;
        addr_out = a;
        @(posedge clock_in);
        #1;
        d = rdata_in;
    endtask
    task automatic idle(input int n);
        wr_out = 1'b0;
        repeat (n) begin
            wdata_out = ~wdata_out;
            @(posedge clock_in);
            #1;
        end
    endtask
endmodule // mau_cpu_model

`default_nettype wire

// file: testbench/mau_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module mau_top_asserts
    import mau_pkg::*;
(
    input wire logic clock_in,            // System clock.
    input wire logic reset_n_in,          // Reset, active low.
    input wire logic [7:0] sfr_addr_in,   // Register address.
    input wire logic sfr_wr_in,           // Write strobe.
    input wire logic [7:0] sfr_wdata_in,  // Write data.
    input wire logic [7:0] sfr_rdata_out  // Read data.
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);
    logic wcfg;
    logic rcfg;
    logic rsta;
    logic wop;
    assign wcfg = sfr_wr_in && sfr_addr_in == ADDR_ARITH_CONFIG;
    assign rcfg = !sfr_wr_in && sfr_addr_in == ADDR_ARITH_CONFIG;
    assign rsta = !sfr_wr_in && sfr_addr_in == ADDR_ARITH_STATUS;
    assign wop = sfr_wr_in && (sfr_addr_in == ADDR_OPERAND_A_LOW ||
        sfr_addr_in == ADDR_OPERAND_A_HIGH ||
        sfr_addr_in == ADDR_OPERAND_B_HIGH);
    ////////////////////////////////////////////////////////////
    a_cfg_top_zero: assert property (
        sfr_addr_in == ADDR_ARITH_CONFIG |=> sfr_rdata_out[7:6] == 2'h0)
        else $error("config upper bits not zero");
    a_sta_top_zero: assert property (
        sfr_addr_in == ADDR_ARITH_STATUS |=> sfr_rdata_out[7:4] == 4'h0)
        else $error("status upper bits not zero");
    a_unmapped_zero: assert property (
        sfr_addr_in == 8'h00 |=> sfr_rdata_out == 8'h00)
        else $error("unmapped address read not zero");
    a_operand_write: assert property (
        wop ##1 (!sfr_wr_in && $stable(sfr_addr_in))
        |=> sfr_rdata_out == $past(sfr_wdata_in, 2))
        else $error("operand byte did not take written value");
    a_cfg_write: assert property (
        wcfg && !sfr_wdata_in[5] && !sfr_wdata_in[3] ##1 rcfg
        |=> sfr_rdata_out == ($past(sfr_wdata_in, 2) & CFG_WRITE_MASK))
        else $error("config read differs from write");
    a_shift_self_clear: assert property (
        wcfg && sfr_wdata_in[5] ##1 rcfg [*2] |=> !sfr_rdata_out[5])
        else $error("shift control did not clear");
    a_clear_self_clear: assert property (
        wcfg && sfr_wdata_in[3] ##1 rcfg [*2] |=> !sfr_rdata_out[3])
        else $error("clear control did not clear");
    a_clear_status: assert property (
        wcfg && sfr_wdata_in[3] &&
        !$past(sfr_wr_in && sfr_addr_in == ADDR_OPERAND_B_LOW_START)
        ##1 rsta [*2] |=> sfr_rdata_out == 8'h04)
        else $error("status not reset by clear");
endmodule // mau_top_asserts

bind mau_top mau_top_asserts i_asrt (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .sfr_addr_in(sfr_addr_in),
    .sfr_wr_in(sfr_wr_in),
    .sfr_wdata_in(sfr_wdata_in),
    .sfr_rdata_out(sfr_rdata_out)
);

`default_nettype wire

// file: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
    import mau_pkg::*;
    logic clock_in;
    logic reset_n_in;
    logic [7:0] addr, wdata, rdata, v, s;
    logic wr;
    logic [39:0] acc;
    int n_fail = 0;
    int samples_checked = 0;
    logic [7:0] zl [10] = '{ADDR_OPERAND_A_LOW, ADDR_OPERAND_A_HIGH,
        ADDR_OPERAND_B_HIGH, ADDR_ACCUM_BYTE0, ADDR_ACCUM_BYTE1,
        ADDR_ACCUM_BYTE2, ADDR_ACCUM_BYTE3, ADDR_ACCUM_TOP_BYTE,
        ADDR_ROUNDED_HIGH, ADDR_ROUNDED_LOW};
    // Each row: config, accumulator, expected rounded value.
    logic [63:0] rt [6] = '{{8'h00, 40'h007fff8000, 16'h8000},
        {8'h04, 40'h007fff8000, 16'h7fff}, {8'h00, 40'h007ffe8000, 16'h7ffe},
        {8'h00, 40'h007ffe8001, 16'h7fff}, {8'h00, 40'h007ffe7fff, 16'h7ffe},
        {8'h04, 40'hff7f000000, 16'h8000}};

    mau_cpu_model i_cpu (.clock_in(clock_in), .rdata_in(rdata),
        .addr_out(addr), .wr_out(wr), .wdata_out(wdata));
    mau_top i_dut (.clock_in(clock_in), .reset_n_in(reset_n_in),
        .sfr_addr_in(addr), .sfr_wr_in(wr), .sfr_wdata_in(wdata),
        .sfr_rdata_out(rdata));

    initial begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [39:0] got, input logic [39:0] exp,
        input string m);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got,
                exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        i_cpu.get_reg(a, v);
        chk({32'h0, v}, {32'h0, e}, $sformatf("reg %h", a));
    endtask
    task automatic wacc(input logic [39:0] x);
        i_cpu.put_reg(ADDR_ACCUM_TOP_BYTE, x[39:32]);
        i_cpu.put_reg(ADDR_ACCUM_BYTE3, x[31:24]);
        i_cpu.put_reg(ADDR_ACCUM_BYTE2, x[23:16]);
        i_cpu.put_reg(ADDR_ACCUM_BYTE1, x[15:8]);
        i_cpu.put_reg(ADDR_ACCUM_BYTE0, x[7:0]);
    endtask
    task automatic racc(input logic [39:0] e);
        i_cpu.get_reg(ADDR_ACCUM_TOP_BYTE, acc[39:32]);
        i_cpu.get_reg(ADDR_ACCUM_BYTE3, acc[31:24]);
        i_cpu.get_reg(ADDR_ACCUM_BYTE2, acc[23:16]);
        i_cpu.get_reg(ADDR_ACCUM_BYTE1, acc[15:8]);
        i_cpu.get_reg(ADDR_ACCUM_BYTE0, acc[7:0]);
        chk(acc, e, "accumulator");
    endtask
    task automatic mac(input logic [15:0] a, input logic [15:0] b,
        input int n);
        i_cpu.put_reg(ADDR_OPERAND_A_HIGH, a[15:8]);
        i_cpu.put_reg(ADDR_OPERAND_A_LOW, a[7:0]);
        i_cpu.put_reg(ADDR_OPERAND_B_HIGH, b[15:8]);
        i_cpu.put_reg(ADDR_OPERAND_B_LOW_START, b[7:0]);
        i_cpu.idle(n);
    endtask
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        reset_n_in = 1'b0;
        repeat (3) @(posedge clock_in);
        #1;
        reset_n_in = 1'b1;
        rchk(ADDR_ARITH_CONFIG, 8'h00);
        rchk(ADDR_ARITH_STATUS, 8'h04);
        foreach (zl[i]) rchk(zl[i], 8'h00);
        i_cpu.put_reg(8'h00, 8'hff);
        rchk(8'h00, 8'h00);
        i_cpu.put_reg(ADDR_ARITH_CONFIG, 8'hc6);
        rchk(ADDR_ARITH_CONFIG, 8'h06);
        i_cpu.put_reg(ADDR_ARITH_STATUS, 8'hf0);
        rchk(ADDR_ARITH_STATUS, 8'h00);
        i_cpu.put_reg(ADDR_OPERAND_A_LOW, 8'h5a);
        rchk(ADDR_OPERAND_A_LOW, 8'h5a);
        $display("Test reset and masks done");
        i_cpu.put_reg(ADDR_ARITH_CONFIG, 8'h01);
        mac(16'h1234, 16'hfedc, 3);
        racc(40'hffffeb3cb0);
        rchk(ADDR_ARITH_STATUS, 8'h01);
        rchk(ADDR_ROUNDED_HIGH, 8'hff);
        rchk(ADDR_ROUNDED_LOW, 8'heb);
        $display("Test multiply only done");
        i_cpu.put_reg(ADDR_ARITH_CONFIG, 8'h0a);
        mac(16'h4000, 16'h2000, 0);
        i_cpu.put_reg(ADDR_OPERAND_B_HIGH, 8'he0);
        i_cpu.put_reg(ADDR_OPERAND_B_LOW_START, 8'h00);
        i_cpu.idle(3);
        racc(40'h0);
        rchk(ADDR_ARITH_STATUS, 8'h04);
        mac(16'h4000, 16'h2000, 3);
        racc(40'h0010000000);
        rchk(ADDR_ROUNDED_HIGH, 8'h10);
        $display("Test fractional accumulate done");
        i_cpu.get_reg(ADDR_ARITH_STATUS, s);
        wacc(40'h4088442211);
        i_cpu.put_reg(ADDR_ARITH_CONFIG, 8'h20);
        i_cpu.get_reg(ADDR_ARITH_CONFIG, v);
        rchk(ADDR_ARITH_CONFIG, 8'h00);
        racc(40'h8110884422);
        i_cpu.put_reg(ADDR_ARITH_CONFIG, 8'h30);
        i_cpu.put_reg(ADDR_ARITH_CONFIG, 8'h30);
        i_cpu.idle(1);
        racc(40'he044221108);
        rchk(ADDR_ARITH_CONFIG, 8'h10);
        rchk(ADDR_ARITH_STATUS, s);
        $display("Test shift done");
        i_cpu.put_reg(ADDR_ARITH_CONFIG, 8'h00);
        wacc(40'h7fffffffff);
        mac(16'h0001, 16'h0001, 3);
        rchk(ADDR_ARITH_STATUS, 8'h0b);
        mac(16'h0000, 16'h0000, 3);
        rchk(ADDR_ARITH_STATUS, 8'h0b);
        i_cpu.put_reg(ADDR_ARITH_CONFIG, 8'h01);
        mac(16'h0001, 16'h0001, 3);
        rchk(ADDR_ARITH_STATUS, 8'h08);
        i_cpu.put_reg(ADDR_ARITH_STATUS, 8'h00);
        rchk(ADDR_ARITH_STATUS, 8'h00);
        i_cpu.put_reg(ADDR_ARITH_STATUS, 8'h0f);
        i_cpu.put_reg(ADDR_ARITH_CONFIG, 8'h08);
        i_cpu.get_reg(ADDR_ARITH_STATUS, v);
        rchk(ADDR_ARITH_STATUS, 8'h04);
        i_cpu.put_reg(ADDR_ARITH_CONFIG, 8'h08);
        i_cpu.get_reg(ADDR_ARITH_CONFIG, v);
        rchk(ADDR_ARITH_CONFIG, 8'h00);
        racc(40'h0);
        $display("Test flags done");
        foreach (rt[i]) begin
            i_cpu.put_reg(ADDR_ARITH_CONFIG, rt[i][63:56]);
            wacc(rt[i][55:16]);
            i_cpu.idle(1);
            rchk(ADDR_ROUNDED_HIGH, rt[i][15:8]);
            rchk(ADDR_ROUNDED_LOW, rt[i][7:0]);
            racc(rt[i][55:16]);
        end
        $display("Test rounding done");
        print_verdict();
    end
endmodule // tb

`default_nettype wire
